// *** rtl/fom_mode_config_regs.sv ***
// Register bank for FSK/OOK operating mode, bit rate and deviation
//
// Our own choice: strobed register access.
`timescale 1ns/1ns
`default_nettype none

module fom_mode_config_regs
    import fom_pkg::*;
(
    input  wire logic            sys_clk,
    input  wire logic            nrst,
    input  wire fom_bus_req_type busReq,
    output var  logic [7:0]      rdData,
    input  wire logic [7:0]      fifoHeadData,
    input  wire logic            manchesterEn,
    output var  logic            fifoPushStrobe,
    output var  logic [7:0]      fifoPushData,
    output var  logic            fifoPopStrobe,
    output var  fom_config_type  cfg,
    output var  logic [19:0]     bitDivisorQ4,
    output var  logic            stateChanged
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rstN;

    fom_reset_sync fom_reset_sync_i
    (
        .sys_clk   (sys_clk),
        .nrstAsync (nrst),
        .nrstSync  (rstN)
    );

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    logic hitFifo;
    logic hitMode;
    logic hitRateHigh;
    logic hitRateLow;
    logic hitDevHigh;
    logic hitDevLow;
    logic hitFraction;
    logic hitTestBank;
    logic wrMode;
    logic modeWriteIsSleep;
    logic modulationCodeOk;
    logic stateCodeOk;
    logic [7:0] next_rdData;
    logic [19:0] next_bitDivisorQ4;
    logic [19:0] chipDivisorQ4;

    assign hitFifo     = busReq.addr == FIFO_DATA_PORT_ADDR;
    assign hitMode     = busReq.addr == OPERATING_MODE_ADDR;
    assign hitRateHigh = busReq.addr == BIT_RATE_DIVISOR_HIGH_ADDR;
    assign hitRateLow  = busReq.addr == BIT_RATE_DIVISOR_LOW_ADDR;
    assign hitDevHigh  = busReq.addr == DEVIATION_WORD_HIGH_ADDR;
    assign hitDevLow   = busReq.addr == DEVIATION_WORD_LOW_ADDR;
    assign hitFraction = busReq.addr == RATE_FRACTION_ADDR;
    assign hitTestBank = busReq.addr >= TEST_BANK_BASE_ADDR;

    assign wrMode = busReq.wrStrobe && hitMode;

    // Gate on the state held before this write, not the one it carries
    assign modeWriteIsSleep = cfg.xcvrState == STATE_SLEEP;

    // Reserved codes are dropped so the modem never sees them
    assign modulationCodeOk =
        busReq.wrData[MODULATION_HI:MODULATION_LO] == MODULATION_FSK ||
        busReq.wrData[MODULATION_HI:MODULATION_LO] == MODULATION_OOK;

    always_comb
    begin
        unique case (busReq.wrData[STATE_HI:STATE_LO])
            STATE_SLEEP,
            STATE_STANDBY,
            STATE_TX_SYNTH,
            STATE_TX,
            STATE_RX_SYNTH,
            STATE_RX:
                stateCodeOk = 1'b1;
            default:
                stateCodeOk = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Operating-mode register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            cfg.modemFamily <= FAMILY_FSK_OOK;
        end
        else if (wrMode && modeWriteIsSleep)
        begin
            cfg.modemFamily <= busReq.wrData[MODEM_FAMILY_BIT];
        end
    end

    always_ff @(posedge sys_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            cfg.modulationScheme <= MODULATION_FSK;
        end
        else if (wrMode && modulationCodeOk)
        begin
            cfg.modulationScheme <=
                busReq.wrData[MODULATION_HI:MODULATION_LO];
        end
    end

    always_ff @(posedge sys_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            cfg.lfTestBankSelect <= LF_BANK_RESET;
        end
        else if (wrMode)
        begin
            cfg.lfTestBankSelect <= busReq.wrData[LF_BANK_BIT];
        end
    end

    always_ff @(posedge sys_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            cfg.xcvrState <= STATE_STANDBY;
        end
        else if (wrMode && stateCodeOk)
        begin
            cfg.xcvrState <= busReq.wrData[STATE_HI:STATE_LO];
        end
    end

    // Pulse lets the sequencer react only to real transitions
    always_ff @(posedge sys_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            stateChanged <= 1'b0;
        end
        else
        begin
            stateChanged <= wrMode && stateCodeOk &&
                (busReq.wrData[STATE_HI:STATE_LO] != cfg.xcvrState);
        end
    end

    // ------------------------------------------------------------------
    // Bit-rate divisor and fraction
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            cfg.rateDivisor[15:8] <= RATE_HIGH_RESET;
        end
        else if (busReq.wrStrobe && hitRateHigh)
        begin
            cfg.rateDivisor[15:8] <= busReq.wrData;
        end
    end

    always_ff @(posedge sys_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            cfg.rateDivisor[7:0] <= RATE_LOW_RESET;
        end
        else if (busReq.wrStrobe && hitRateLow)
        begin
            cfg.rateDivisor[7:0] <= busReq.wrData;
        end
    end

    always_ff @(posedge sys_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            cfg.rateDivisorFraction <= RATE_FRAC_RESET;
        end
        else if (busReq.wrStrobe && hitFraction)
        begin
            cfg.rateDivisorFraction <= busReq.wrData[FRACTION_W-1:0];
        end
    end

    // Divisor in sixteenths: whole part shifted up, fraction below
    assign chipDivisorQ4 = {cfg.rateDivisor, cfg.rateDivisorFraction};

    // With Manchester the register sets the chip rate, so data is halved
    always_comb
    begin
        if (manchesterEn)
        begin
            next_bitDivisorQ4 = {chipDivisorQ4[18:0], 1'b0};
        end
        else
        begin
            next_bitDivisorQ4 = chipDivisorQ4;
        end
    end

    always_ff @(posedge sys_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            bitDivisorQ4 <= {RATE_HIGH_RESET, RATE_LOW_RESET,
                             RATE_FRAC_RESET};
        end
        else
        begin
            bitDivisorQ4 <= next_bitDivisorQ4;
        end
    end

    // ------------------------------------------------------------------
    // Frequency-deviation word
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            cfg.deviationWord[13:8] <= DEV_HIGH_RESET;
        end
        else if (busReq.wrStrobe && hitDevHigh)
        begin
            cfg.deviationWord[13:8] <= busReq.wrData[DEV_HIGH_W-1:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            cfg.deviationWord[7:0] <= DEV_LOW_RESET;
        end
        else if (busReq.wrStrobe && hitDevLow)
        begin
            cfg.deviationWord[7:0] <= busReq.wrData;
        end
    end

    // ------------------------------------------------------------------
    // FIFO access port
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            fifoPushStrobe <= 1'b0;
            fifoPopStrobe  <= 1'b0;
        end
        else
        begin
            fifoPushStrobe <= busReq.wrStrobe && hitFifo;
            fifoPopStrobe  <= busReq.rdStrobe && hitFifo;
        end
    end

    always_ff @(posedge sys_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            fifoPushData <= FIFO_DATA_RESET;
        end
        else if (busReq.wrStrobe && hitFifo)
        begin
            fifoPushData <= busReq.wrData;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Test bank contents live elsewhere; this bank answers them with zero
    always_comb
    begin
        next_rdData = 8'h00;
        if (hitFifo)
        begin
            next_rdData = fifoHeadData;
        end
        else if (hitMode)
        begin
            next_rdData[MODEM_FAMILY_BIT]            = cfg.modemFamily;
            next_rdData[MODULATION_HI:MODULATION_LO] = cfg.modulationScheme;
            next_rdData[LF_BANK_BIT]                 = cfg.lfTestBankSelect;
            next_rdData[STATE_HI:STATE_LO]           = cfg.xcvrState;
            // Bit 4 left at zero
        end
        else if (hitRateHigh)
        begin
            next_rdData = cfg.rateDivisor[15:8];
        end
        else if (hitRateLow)
        begin
            next_rdData = cfg.rateDivisor[7:0];
        end
        else if (hitDevHigh)
        begin
            next_rdData[DEV_HIGH_W-1:0] = cfg.deviationWord[13:8];
        end
        else if (hitDevLow)
        begin
            next_rdData = cfg.deviationWord[7:0];
        end
        else if (hitFraction)
        begin
            next_rdData[FRACTION_W-1:0] = cfg.rateDivisorFraction;
        end
        else if (hitTestBank)
        begin
            next_rdData = 8'h00;
        end
    end

    // Data stand only in the cycle after the read strobe
    always_ff @(posedge sys_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            rdData <= 8'h00;
        end
        else if (busReq.rdStrobe)
        begin
            rdData <= next_rdData;
        end
        else
        begin
            rdData <= 8'h00;
        end
    end

endmodule

`default_nettype wire

// *** rtl/fom_pkg.sv ***
// Constants and carrier types for the FSK/OOK mode configuration bank
package fom_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [6:0] FIFO_DATA_PORT_ADDR        = 7'h00;
    localparam logic [6:0] OPERATING_MODE_ADDR        = 7'h01;
    localparam logic [6:0] BIT_RATE_DIVISOR_HIGH_ADDR = 7'h02;
    localparam logic [6:0] BIT_RATE_DIVISOR_LOW_ADDR  = 7'h03;
    localparam logic [6:0] DEVIATION_WORD_HIGH_ADDR   = 7'h04;
    localparam logic [6:0] DEVIATION_WORD_LOW_ADDR    = 7'h05;
    localparam logic [6:0] RATE_FRACTION_ADDR         = 7'h5D;
    localparam logic [6:0] TEST_BANK_BASE_ADDR        = 7'h61;

    // ------------------------------------------------------------------
    // Operating-mode field positions; deviation-high and fraction field widths
    // ------------------------------------------------------------------
    localparam int MODEM_FAMILY_BIT = 7;
    localparam int MODULATION_HI    = 6;
    localparam int MODULATION_LO    = 5;
    localparam int LF_BANK_BIT      = 3;
    localparam int STATE_HI         = 2;
    localparam int STATE_LO         = 0;
    localparam int DEV_HIGH_W       = 6;
    localparam int FRACTION_W       = 4;

    // ------------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------------
    localparam logic       FAMILY_FSK_OOK    = 1'b0;
    localparam logic [1:0] MODULATION_FSK    = 2'h0;
    localparam logic [1:0] MODULATION_OOK    = 2'h1;
    localparam logic [2:0] STATE_SLEEP       = 3'h0;
    localparam logic [2:0] STATE_STANDBY     = 3'h1;
    localparam logic [2:0] STATE_TX_SYNTH    = 3'h2;
    localparam logic [2:0] STATE_TX          = 3'h3;
    localparam logic [2:0] STATE_RX_SYNTH    = 3'h4;
    localparam logic [2:0] STATE_RX          = 3'h5;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic       LF_BANK_RESET      = 1'b1;
    localparam logic [7:0] FIFO_DATA_RESET    = 8'h00;
    localparam logic [7:0] RATE_HIGH_RESET    = 8'h1A;
    localparam logic [7:0] RATE_LOW_RESET     = 8'h0B;
    localparam logic [5:0] DEV_HIGH_RESET     = 6'h00;
    localparam logic [7:0] DEV_LOW_RESET      = 8'h52;
    localparam logic [3:0] RATE_FRAC_RESET    = 4'h0;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wrData;
        logic              wrStrobe;
        logic              rdStrobe;
    } fom_bus_req_type;

    typedef struct packed {
        logic        modemFamily;
        logic [1:0]  modulationScheme;
        logic        lfTestBankSelect;
        logic [2:0]  xcvrState;
        logic [15:0] rateDivisor;
        logic [3:0]  rateDivisorFraction;
        logic [13:0] deviationWord;
    } fom_config_type;

endpackage

// *** rtl/fom_reset_sync.sv ***
// Two-stage release synchroniser for the active-low reset
`timescale 1ns/1ns
`default_nettype none

module fom_reset_sync
(
    input  wire logic sys_clk,
    input  wire logic nrstAsync,
    output var  logic nrstSync
);

    logic stage1;

    // ------------------------------------------------------------------
    // Assert at once, release after two edges
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrstAsync)
    begin
        if (!nrstAsync)
        begin
            stage1   <= 1'b0;
            nrstSync <= 1'b0;
        end
        else
        begin
            stage1   <= 1'b1;
            nrstSync <= stage1;
        end
    end

endmodule

`default_nettype wire

// *** tb/fom_props.sv ***
// Checker for the mode configuration bank ports
`timescale 1ns/1ns
`default_nettype none
module fom_props
    import fom_pkg::*;
(
    input  wire logic            sys_clk,
    input  wire logic            nrst,
    input  wire fom_bus_req_type busReq,
    input  wire logic [7:0]      rdData,
    input  wire logic [7:0]      fifoHeadData,
    input  wire logic            manchesterEn,
    input  wire logic            fifoPushStrobe,
    input  wire logic [7:0]      fifoPushData,
    input  wire logic            fifoPopStrobe,
    input  wire fom_config_type  cfg,
    input  wire logic [19:0]     bitDivisorQ4,
    input  wire logic            stateChanged
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    logic wrMode;
    assign wrMode = busReq.wrStrobe && busReq.addr == 7'h01;

    a_push_after_write: assert property (
        busReq.wrStrobe && busReq.addr == 7'h00
        |=> fifoPushStrobe && fifoPushData == $past(busReq.wrData))
        else $error("fifo push missing");
    a_pop_after_read: assert property (
        busReq.rdStrobe && busReq.addr == 7'h00
        |=> fifoPopStrobe && rdData == $past(fifoHeadData))
        else $error("fifo pop missing");
    a_family_locked: assert property (
        wrMode && cfg.xcvrState != 3'h0
        |=> $stable(cfg.modemFamily))
        else $error("family changed outside sleep");
    a_mod_reserved: assert property (
        wrMode && busReq.wrData[6]
        |=> $stable(cfg.modulationScheme))
        else $error("reserved modulation taken");
    a_state_reserved: assert property (
        wrMode && busReq.wrData[2:1] == 2'h3
        |=> $stable(cfg.xcvrState))
        else $error("reserved state taken");
    a_state_pulse: assert property (
        stateChanged == $past(wrMode && busReq.wrData[2:1] != 2'h3
            && busReq.wrData[2:0] != cfg.xcvrState))
        else $error("state change pulse wrong");
    a_mode_readback: assert property (
        busReq.rdStrobe && busReq.addr == 7'h01
        |=> rdData == {cfg.modemFamily, cfg.modulationScheme, 1'b0,
                       cfg.lfTestBankSelect, cfg.xcvrState})
        else $error("mode readback wrong");
    a_rate_high: assert property (
        busReq.wrStrobe && busReq.addr == 7'h02
        |=> cfg.rateDivisor[15:8] == $past(busReq.wrData))
        else $error("rate high not stored");
    a_dev_high: assert property (
        busReq.wrStrobe && busReq.addr == 7'h04
        |=> cfg.deviationWord[13:8] == $past(busReq.wrData[5:0]))
        else $error("deviation high not stored");
    a_rd_idle: assert property (!busReq.rdStrobe |=> rdData == 8'h00)
        else $error("read data outside slot");
    a_reset_values: assert property (
        $rose(nrst) |-> cfg.xcvrState == 3'h1
        && cfg.rateDivisor == 16'h1A0B && cfg.deviationWord == 14'h0052
        && cfg.lfTestBankSelect && !cfg.modemFamily
        && cfg.modulationScheme == 2'h0)
        else $error("reset values wrong");
    c_sleep_write: cover property (wrMode && cfg.xcvrState == 3'h0);
    c_fifo_pop: cover property (fifoPopStrobe);
    c_state_change: cover property (stateChanged);
    c_family_set: cover property (cfg.modemFamily);
endmodule
bind fom_mode_config_regs fom_props fom_props_i (.sys_clk(sys_clk),
    .nrst(nrst), .busReq(busReq), .rdData(rdData),
    .fifoHeadData(fifoHeadData), .manchesterEn(manchesterEn),
    .fifoPushStrobe(fifoPushStrobe), .fifoPushData(fifoPushData),
    .fifoPopStrobe(fifoPopStrobe), .cfg(cfg),
    .bitDivisorQ4(bitDivisorQ4), .stateChanged(stateChanged));
`default_nettype wire

// *** tb/fom_host_model.sv ***
// Host bus master and external FIFO head model
`timescale 1ns/1ns
`default_nettype none
module fom_host_model
    import fom_pkg::*;
(
    input  wire logic            sys_clk,
    input  wire logic            fifoPopStrobe,
    output var  fom_bus_req_type busReq,
    output var  logic [7:0]      fifoHeadData
);
    initial busReq = '0;
    initial fifoHeadData = 8'hA5;
    // Head moves on every pop so a stale byte cannot pass
    always @(posedge sys_clk)
        if (fifoPopStrobe)
            fifoHeadData <= fifoHeadData + 8'h3D;
    // One strobe cycle; caller ends a burst with idle
    task automatic xfer(input logic w, input logic [6:0] a,
                        input logic [7:0] d);
        busReq <= '{a, d, w, !w};
        @(posedge sys_clk);
    endtask
    task automatic idle;
        busReq <= '0;
        @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

// *** tb/tb_fom_mode_config_regs.sv ***
// Self-checking bench for the mode configuration bank
`timescale 1ns/1ns
`default_nettype none
module tb_fom_mode_config_regs;
    import fom_pkg::*;
    logic            sys_clk, nrst, manchesterEn, rdPend;
    logic            fifoPushStrobe, fifoPopStrobe, stateChanged;
    logic [7:0]      rdData, fifoPushData, fifoHeadData, mode, r8;
    logic [15:0]     rate;
    logic [19:0]     bitDivisorQ4;
    fom_bus_req_type busReq;
    fom_config_type  cfg;
    logic [7:0]      expQ[$];
    int              miscompares = 0;
    int              n_checks = 0;

    fom_host_model host_i (.sys_clk(sys_clk), .fifoPopStrobe(fifoPopStrobe),
        .busReq(busReq), .fifoHeadData(fifoHeadData));
    fom_mode_config_regs fom_mode_config_regs_i (.sys_clk(sys_clk),
        .nrst(nrst), .busReq(busReq), .rdData(rdData),
        .fifoHeadData(fifoHeadData), .manchesterEn(manchesterEn),
        .fifoPushStrobe(fifoPushStrobe), .fifoPushData(fifoPushData),
        .fifoPopStrobe(fifoPopStrobe), .cfg(cfg),
        .bitDivisorQ4(bitDivisorQ4), .stateChanged(stateChanged));

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ----------
    // Tasks
    // ----------
    task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
            miscompares++;
        end
    endtask
    task automatic end_sim;
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        expQ.push_back(e);
        host_i.xfer(1'b0, a, 8'h00);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        if (a == 7'h02)
            rate[15:8] = d;
        if (a == 7'h03)
            rate[7:0] = d;
        host_i.xfer(1'b1, a, d);
    endtask
    task automatic mode_wr(input logic [7:0] d);
        if (mode[2:0] == STATE_SLEEP)
            mode[7] = d[7];
        if (!d[6])
            mode[6:5] = d[6:5];
        mode[3] = d[3];
        if (d[2:1] != 2'h3)
            mode[2:0] = d[2:0];
        wr(OPERATING_MODE_ADDR, d);
        rd(OPERATING_MODE_ADDR, mode);
    endtask
    task automatic do_reset;
        nrst <= 1'b0;
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        mode = 8'h09;
        rate = 16'h1A0B;
    endtask
    task automatic chk_defaults;
        rd(7'h01, 8'h09);
        rd(7'h02, RATE_HIGH_RESET);
        rd(7'h03, RATE_LOW_RESET);
        rd(7'h04, 8'h00);
        rd(7'h05, DEV_LOW_RESET);
        host_i.idle();
    endtask

    // Read data checked against the oldest note one cycle later
    always @(posedge sys_clk)
        rdPend <= busReq.rdStrobe;
    always @(negedge sys_clk)
        if (rdPend)
            chk(20'(rdData), 20'(expQ.pop_front()));

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        end_sim();
    end

    // ----------
    // Main sequence
    // ----------
    initial
    begin
        nrst = 1'b0;
        manchesterEn = 1'b0;
        void'($urandom(32'h6eb43b2a));
        do_reset();
        chk_defaults();
        @(negedge sys_clk);
        chk(bitDivisorQ4, 20'h1A0B0);
        for (int i = 0; i < 64; i++)
        begin
            r8 = $urandom;
            mode_wr({r8[7], i[4:3], r8[4], r8[3], i[2:0]});
        end
        for (int i = 0; i < 16; i++)
        begin
            r8 = $urandom;
            manchesterEn <= r8[1];
            wr(7'(2 + i % 4), r8);
            rd(7'(2 + i % 4), (i % 4 == 2) ? (r8 & 8'h3F) : r8);
        end
        wr(7'h5D, 8'hFF);
        rd(7'h5D, 8'h0F);
        wr(7'h06, 8'hFF);
        wr(7'h61, 8'hFF);
        wr(7'h00, r8);
        rd(7'h06, 8'h00);
        rd(7'h61, 8'h00);
        rd(7'h02, rate[15:8]);
        host_i.idle();
        repeat (2) @(negedge sys_clk);
        chk(bitDivisorQ4, 20'({rate, 4'hF} << manchesterEn));
        chk(20'(fifoPushData), 20'(r8));
        for (int i = 0; i < 3; i++)
        begin
            @(posedge sys_clk);
            rd(7'h00, fifoHeadData);
            host_i.idle();
            host_i.idle();
        end
        do_reset();
        chk_defaults();
        repeat (2) @(posedge sys_clk);
        end_sim();
    end
endmodule
`default_nettype wire
